// ==== hw/lprm_ctrl.sv ====
`timescale 1ns/1ns
module lprm_ctrl #(
    parameter int IO_COUNT    = lprm_pkg::IO_COUNT,
    parameter int STATE_WIDTH = lprm_pkg::STATE_WIDTH
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Freeze pin and its use
    input  wire logic                   freeze_n_in,
    input  wire logic                   freeze_enable,
    output logic                        freeze_pin_user,
    output logic                        freeze_level_core,
    // Status
    output logic                        frozen,
    output logic                        core_clk_en,
    // Retained core state
    input  wire logic [STATE_WIDTH-1:0] core_next_state,
    output logic [STATE_WIDTH-1:0]      core_state,
    // I/O configuration
    input  wire logic [IO_COUNT-1:0]    io_tristate_sel,
    input  wire logic [IO_COUNT-1:0]    io_pull_en,
    input  wire logic [IO_COUNT-1:0]    io_pull_up,
    // User I/O drive
    input  wire logic [IO_COUNT-1:0]    user_out,
    input  wire logic [IO_COUNT-1:0]    user_oe,
    input  wire logic [IO_COUNT-1:0]    pad_in,
    output logic [IO_COUNT-1:0]         pad_out,
    output logic [IO_COUNT-1:0]         pad_oe,
    output logic [IO_COUNT-1:0]         pad_pull_up,
    output logic [IO_COUNT-1:0]         pad_pull_dn,
    output logic [IO_COUNT-1:0]         core_in
);
    lprm_pin_if pin_bus ();
    logic                  sync_level;
    lprm_pkg::lprm_mode_e  mode;
    lprm_pkg::lprm_mode_e  next_mode;

    lprm_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_in  (freeze_n_in),
        .level   (sync_level)
    );

    assign pin_bus.freeze_req = freeze_enable && (sync_level == lprm_pkg::FREEZE_ACTIVE);

    // Entry and exit each take two state steps, far inside the latency limit.
    always_comb begin
        next_mode = mode;
        unique case (mode)
            lprm_pkg::LPRM_ACTIVE: if (pin_bus.freeze_req) next_mode = lprm_pkg::LPRM_ENTER;
            lprm_pkg::LPRM_ENTER:  next_mode = lprm_pkg::LPRM_FROZEN;
            lprm_pkg::LPRM_FROZEN: if (!pin_bus.freeze_req) next_mode = lprm_pkg::LPRM_EXIT;
            lprm_pkg::LPRM_EXIT:   next_mode = lprm_pkg::LPRM_ACTIVE;
        endcase
    end

    wire hold_now  = (next_mode == lprm_pkg::LPRM_FROZEN) || (next_mode == lprm_pkg::LPRM_EXIT);
    wire [IO_COUNT-1:0] next_oe = hold_now ? (pad_oe & ~io_tristate_sel) : user_oe;

    assign pin_bus.frozen = (mode == lprm_pkg::LPRM_FROZEN);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode              <= lprm_pkg::LPRM_ACTIVE;
            frozen            <= 1'b0;
            core_clk_en       <= 1'b1;
            core_state        <= '0;
            pad_out           <= '0;
            pad_oe            <= '0;
            pad_pull_up       <= '0;
            pad_pull_dn       <= '0;
            core_in           <= '0;
            freeze_pin_user   <= 1'b1;
            freeze_level_core <= 1'b1;
        end else begin
            mode              <= next_mode;
            frozen            <= hold_now;
            core_clk_en       <= !hold_now;
            freeze_level_core <= sync_level;
            freeze_pin_user   <= freeze_enable ? 1'b1 : sync_level;
            if (!hold_now) begin
                core_state <= core_next_state;
                pad_out    <= user_out;
                core_in    <= pad_in;
            end
            pad_oe      <= next_oe;
            pad_pull_up <= hold_now ? (io_pull_en & io_pull_up) : '0;
            pad_pull_dn <= hold_now ? (io_pull_en & ~io_pull_up) : '0;
        end
    end
endmodule // lprm_ctrl

// ==== hw/lprm_pin_if.sv ====
`timescale 1ns/1ns
interface lprm_pin_if;
    logic freeze_req;
    logic frozen;
    modport sync_end (output freeze_req);
    modport ctrl_end (input freeze_req, output frozen);
endinterface

// ==== hw/lprm_pkg.sv ====
package lprm_pkg;

    localparam int  CLK_PERIOD_NS   = 10;
    localparam int  FREEZE_LIMIT_NS = 1000;
    // Longest allowed latency rounds down to whole cycles.
    localparam int  FREEZE_LIMIT_CYC = FREEZE_LIMIT_NS / CLK_PERIOD_NS;
    localparam int  SYNC_STAGES     = 3;
    localparam int  IO_COUNT        = 8;
    localparam int  STATE_WIDTH     = 16;
    localparam logic FREEZE_ACTIVE  = 1'b0;

    typedef enum logic [1:0] {
        LPRM_ACTIVE,
        LPRM_ENTER,
        LPRM_FROZEN,
        LPRM_EXIT
    } lprm_mode_e;

endpackage

// ==== hw/lprm_sync.sv ====
`timescale 1ns/1ns
module lprm_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Raw pin
    input  wire logic pin_in,
    // Filtered level
    output logic      level
);
    logic [lprm_pkg::SYNC_STAGES-1:0] stage;
    wire agree = stage[1] == stage[2];

    // A pin change only counts once the last two stages agree.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage <= {lprm_pkg::SYNC_STAGES{1'b1}};
            level <= 1'b1;
        end else begin
            stage <= {stage[lprm_pkg::SYNC_STAGES-2:0], pin_in};
            if (agree) begin
                level <= stage[2];
            end
        end
    end
endmodule // lprm_sync

// ==== sim/lprm_ctrl_asserts.sv ====
`timescale 1ns/1ns
module lprm_ctrl_asserts #(parameter int IO_COUNT = 8, parameter int STATE_WIDTH = 16) (
    // Pin, status and state
    input wire logic clk, sys_rst, freeze_n_in, freeze_enable, frozen,
    input wire logic freeze_pin_user, freeze_level_core,
    input wire logic [STATE_WIDTH-1:0] core_state,
    // Pads and their setup
    input wire logic [IO_COUNT-1:0] pad_out, pad_oe, pad_pull_dn,
    input wire logic [IO_COUNT-1:0] io_tristate_sel, io_pull_en, io_pull_up
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_enter_fast: assert property ((freeze_enable && !freeze_n_in) [*8] |-> frozen)
        else $error("late entry");
    a_exit_fast: assert property (freeze_n_in [*8] |-> !frozen)
        else $error("late exit");
    a_state_kept: assert property (frozen ##1 frozen |-> $stable(core_state))
        else $error("state moved");
    a_pads_kept: assert property (frozen ##1 frozen |-> $stable(pad_out))
        else $error("pad moved");
    a_pad_float: assert property (frozen ##1 frozen |-> !(pad_oe & io_tristate_sel))
        else $error("pad driven");
    a_pull_down: assert property (frozen ##1 frozen |-> pad_pull_dn == (io_pull_en & ~io_pull_up))
        else $error("bad pull");
    // Five steady samples cover the three sync stages, the filter and the output register.
    a_core_level: assert property ($stable(freeze_n_in) [*5] |-> freeze_level_core == freeze_n_in)
        else $error("bad level");
    a_user_pin: assert property ((!freeze_enable && $stable(freeze_n_in)) [*5] |-> freeze_pin_user == freeze_n_in)
        else $error("bad user pin");
    cover property ($rose(frozen));
    cover property ($fell(frozen));
    cover property (!freeze_enable && !freeze_n_in);
endmodule // lprm_ctrl_asserts
bind lprm_ctrl lprm_ctrl_asserts #(.IO_COUNT(IO_COUNT), .STATE_WIDTH(STATE_WIDTH)) chk_u (.*);

// ==== sim/lprm_pin_model.sv ====
`timescale 1ns/1ns
module lprm_pin_model (
    input wire logic clk,
    input wire logic req,
    output logic     freeze_n = 1'b1
);
    // Low asks for retention, high resumes.
    always @(negedge clk) freeze_n <= !req;
endmodule // lprm_pin_model

// ==== sim/tb_lprm_ctrl.sv ====
`timescale 1ns/1ns
module tb_lprm_ctrl;
    logic clk = 0, sys_rst = 1, freeze_enable = 1, req = 0, freeze_n_in;
    logic freeze_pin_user, freeze_level_core, frozen, core_clk_en;
    logic [15:0] core_next_state = 16'h1234, core_state;
    logic [7:0] io_tristate_sel = 8'h0F, io_pull_en = 8'h33, io_pull_up = 8'h11;
    logic [7:0] user_out = 8'hA5, user_oe = 8'hFF, pad_in = 8'h00;
    logic [7:0] pad_out, pad_oe, pad_pull_up, pad_pull_dn, core_in;
    int num_errors = 0, cmp_count = 0, n;
    lprm_ctrl dut_u (.*);
    lprm_pin_model pin_u (.clk(clk), .req(req), .freeze_n(freeze_n_in));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // The wait is capped at the latency limit in whole cycles.
    task automatic wait_frozen(input logic lvl);
        for (n = 0; n < lprm_pkg::FREEZE_LIMIT_CYC && frozen !== lvl; n++) @(negedge clk);
        chk(frozen, lvl);
    endtask
    task automatic t_retain;
        req = 1;
        wait_frozen(1);
        user_out = 8'h5A;
        user_oe = 8'h00;
        pad_in = 8'hFF;
        core_next_state = 16'h5678;
        repeat (10) @(negedge clk);
        chk(core_state, 16'h1234);
        chk(pad_out, 8'hA5);
        chk(pad_oe, 8'hF0);
        chk({pad_pull_up, pad_pull_dn}, 16'h1122);
        chk(core_clk_en, 1'b0);
        chk(core_in, 8'h00);
        req = 0;
        wait_frozen(0);
        repeat (2) @(negedge clk);
        chk(core_state, 16'h5678);
        chk(core_clk_en, 1'b1);
        chk(core_in, 8'hFF);
        chk(pad_out, 8'h5A);
        chk(pad_oe, 8'h00);
        $display("test retain done");
    endtask
    task automatic t_user_io;
        freeze_enable = 0;
        req = 1;
        repeat (20) @(negedge clk);
        chk(frozen, 0);
        chk(freeze_pin_user, 0);
        chk(freeze_level_core, 0);
        $display("test user io done");
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        sys_rst = 0;
        t_retain;
        t_user_io;
        tally_and_finish;
    end
    initial begin
        #5000;
        num_errors++;
        tally_and_finish;
    end
endmodule // tb_lprm_ctrl
